/* File: rtl/udc_pkg.sv */
// Package: register map, field positions, reset values and timing of the device register block
package udc_pkg;
    // Register byte offsets (word aligned, low address byte decoded)
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_IEN = 8'h04;
    localparam logic [7:0] OFF_ADDR = 8'h08;
    localparam logic [7:0] OFF_FRAME_COUNTER_VALUE_HI = 8'h0C;
    localparam logic [7:0] OFF_FRAME_COUNTER_VALUE_LO = 8'h10;
    localparam logic [7:0] OFF_FN_ERR = 8'h14;
    localparam logic [7:0] OFF_EP_SEL = 8'h18;
    localparam logic [7:0] OFF_EP_RST = 8'h1C;
    localparam logic [7:0] OFF_EP_CTL = 8'h20;
    localparam logic [7:0] OFF_EP_CFG = 8'h24;

    // Device flag and enable bit positions
    localparam int FL_REMOTE = 6;
    localparam int FL_RESUME = 5;
    localparam int FL_WAKE = 4;
    localparam int FL_RESET = 3;
    localparam int FL_SOF = 2;
    localparam int FL_SUSP = 0;
    localparam logic [7:0] FLAG_MASK = 8'h7D;

    // Address, frame and endpoint field positions
    localparam int ADDR_VALID_BIT = 7;
    localparam int FN_CRC_BIT = 4;
    localparam int EPC_STALL = 5;
    localparam int EPC_CANCEL = 4;
    localparam int EPC_TOGGLE = 3;
    localparam int EPC_ACTIVE = 0;
    localparam int CFG_KIND_LO = 6;
    localparam int CFG_DIR = 0;
    localparam int NUM_EP = 5;

    // Reset values
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_IEN = 8'h00;
    localparam logic [7:0] RST_ADDR = 8'h00;

    // Suspend detection: idle longer than 3 ms at 5 ns per cycle, rounded up
    localparam int CLK_PERIOD_NS = 5;
    localparam int SUSPEND_IDLE_NS = 3_000_000;
    localparam int SUSPEND_CYCLES = (SUSPEND_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W = 20;

    typedef enum logic [1:0] {
        KIND_CONTROL = 2'b00,
        KIND_ISO = 2'b01,
        KIND_BULK = 2'b10,
        KIND_INTR = 2'b11
    } udc_kind_t;

    // Whole state of the register block
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] ien;
        logic [6:0] dev_addr;
        logic addr_valid;
        logic [10:0] frame;
        logic fn_err;
        logic [2:0] ep_sel;
        logic [4:0] ep_rst;
        logic [4:0] ep_act;
        logic [4:0] ep_stall;
        logic [4:0] ep_tgl;
        logic [4:0][1:0] ep_kind;
        logic [4:0] ep_dir;
        logic [4:0] ep_dir_eff;
        logic [IDLE_CNT_W-1:0] idle_cnt;
        logic idle_prev;
        logic irq;
        logic addr_hit;
        logic dp_wr;
        logic [7:0] dp_off;
        logic [31:0] rdata;
        logic hready;
    } udc_state_t;
endpackage

/* File: rtl/udc_regs.sv */
// Device register block: bus-event flags, address, frame number and endpoint control
`timescale 1ns/1ps

// Functional notes
// - Set resume-end flag on host resume end
// - Set wake flag on non-idle lines only
// - Set reset-end flag when bus reset ends
// - Set frame-start flag on every SOF
// - Set suspend flag after over 3ms idle
// - Flags set regardless of their enables
// - Interrupt needs flag, enable and global enable
// - Write zero clears flag, one keeps it
// - Answer programmed address only once enabled
// - Capture 11-bit frame number, even corrupted
// - Bad SOF CRC sets error and SOF flags
// - Endpoint select steers per-endpoint registers
// - Endpoint reset bit holds endpoint in reset
// - Stall request set by write, hardware clears
// - Stall cancel drops pending stall, self-clears
// - Toggle reset pulses once, self-clears
// - Enable bit activates or deactivates endpoint
// - Type field: control, iso, bulk, interrupt
// - Direction ignored for control endpoints
// - Reserved bits read as zero
// - Set remote-resume flag after resume sent
module udc_regs #(
    parameter int SUSPEND_CYCLES = udc_pkg::SUSPEND_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic resume_end_evt,
    input wire logic bus_reset_end_evt,
    input wire logic remote_resume_sent_evt,
    input wire logic bus_idle,
    input wire logic sof_evt,
    input wire logic sof_crc_bad,
    input wire logic [10:0] sof_frame,
    input wire logic tok_valid,
    input wire logic [6:0] tok_addr,
    input wire logic stall_sent_evt,
    input wire logic setup_rcvd_evt,
    input wire logic [2:0] xfer_ep,
    input wire logic cpu_global_ie,
    output logic usb_irq_req,
    output logic addr_hit,
    output logic [4:0] endpoint_hold_reset,
    output logic [4:0] endpoint_active,
    output logic [4:0] stall_request,
    output logic [4:0] toggle_reset,
    output logic [9:0] endpoint_transfer_kind,
    output logic [4:0] endpoint_direction
);
    udc_pkg::udc_state_t q;
    udc_pkg::udc_state_t d;
    logic [4:0] sel_hot;
    logic [4:0] xfer_hot;

    // One-hot endpoint decode; indices past the last endpoint select nothing
    function automatic logic [4:0] ep_onehot(input logic [2:0] idx);
        logic [4:0] v;
        v = '0;
        if (idx < 3'(udc_pkg::NUM_EP))
        begin
            v[idx] = 1'b1;
        end
        return v;
    endfunction

    // Register read view; unmapped offsets and reserved bits give zero
    function automatic logic [7:0] rd_byte(input udc_pkg::udc_state_t s, input logic [7:0] off);
        logic [7:0] v;
        logic [4:0] h;
        v = 8'h00;
        h = ep_onehot(s.ep_sel);

        unique case (off)
            udc_pkg::OFF_FLAGS: v = s.flags & udc_pkg::FLAG_MASK;
            udc_pkg::OFF_IEN: v = s.ien & udc_pkg::FLAG_MASK;
            udc_pkg::OFF_ADDR: v = {s.addr_valid, s.dev_addr};
            udc_pkg::OFF_FRAME_COUNTER_VALUE_HI: v = {5'h00, s.frame[10:8]};
            udc_pkg::OFF_FRAME_COUNTER_VALUE_LO: v = s.frame[7:0];
            udc_pkg::OFF_FN_ERR: v = 8'(s.fn_err) << udc_pkg::FN_CRC_BIT;
            udc_pkg::OFF_EP_SEL: v = {5'h00, s.ep_sel};
            udc_pkg::OFF_EP_RST: v = {3'h0, s.ep_rst};
            udc_pkg::OFF_EP_CTL: v = {2'h0, |(s.ep_stall & h), 4'h0, |(s.ep_act & h)};
            udc_pkg::OFF_EP_CFG:
                for (int i = 0; i < udc_pkg::NUM_EP; i++)
                begin
                    if (h[i])
                    begin
                        v = {s.ep_kind[i], 5'h00, s.ep_dir[i]};
                    end
                end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Next-state logic; hardware stall clears first, then data-phase writes, then event sets, so a set wins a clear
    always_comb
    begin
        d = q;
        d.ep_tgl = '0;
        d.hready = 1'b1;
        sel_hot = ep_onehot(q.ep_sel);
        xfer_hot = ep_onehot(xfer_ep);

        // Hardware clears of a pending stall
        for (int i = 0; i < udc_pkg::NUM_EP; i++)
        begin
            if (xfer_hot[i] && (stall_sent_evt || setup_rcvd_evt))
            begin
                d.ep_stall[i] = 1'b0;
            end
        end

        // Software writes in the data phase
        if (q.dp_wr)
        begin
            unique case (q.dp_off)
                udc_pkg::OFF_FLAGS: d.flags = q.flags & hwdata[7:0] & udc_pkg::FLAG_MASK;
                udc_pkg::OFF_IEN: d.ien = hwdata[7:0] & udc_pkg::FLAG_MASK;
                udc_pkg::OFF_ADDR:
                begin
                    d.dev_addr = hwdata[6:0];
                    d.addr_valid = hwdata[udc_pkg::ADDR_VALID_BIT];
                end
                udc_pkg::OFF_EP_SEL: d.ep_sel = hwdata[2:0];
                udc_pkg::OFF_EP_RST: d.ep_rst = hwdata[4:0];
                udc_pkg::OFF_EP_CTL:
                    for (int i = 0; i < udc_pkg::NUM_EP; i++)
                    begin
                        if (sel_hot[i])
                        begin
                            // A software request wins a same-cycle hardware clear
                            if (hwdata[udc_pkg::EPC_STALL])
                            begin
                                d.ep_stall[i] = 1'b1;
                            end
                            if (hwdata[udc_pkg::EPC_CANCEL])
                            begin
                                d.ep_stall[i] = 1'b0;
                            end
                            d.ep_tgl[i] = hwdata[udc_pkg::EPC_TOGGLE];
                            d.ep_act[i] = hwdata[udc_pkg::EPC_ACTIVE];
                        end
                    end
                udc_pkg::OFF_EP_CFG:
                    for (int i = 0; i < udc_pkg::NUM_EP; i++)
                    begin
                        if (sel_hot[i])
                        begin
                            d.ep_kind[i] = hwdata[udc_pkg::CFG_KIND_LO +: 2];
                            d.ep_dir[i] = hwdata[udc_pkg::CFG_DIR];
                        end
                    end
                default: d.flags = d.flags; // Read-only or unmapped: write ignored
            endcase
        end

        // An endpoint held in reset loses any pending stall
        d.ep_stall = d.ep_stall & ~d.ep_rst;

        // Effective direction: control endpoints are bidirectional
        for (int i = 0; i < udc_pkg::NUM_EP; i++)
        begin
            d.ep_dir_eff[i] = d.ep_dir[i] && (d.ep_kind[i] != udc_pkg::KIND_CONTROL);
        end

        // Idle counter saturates so suspend is flagged once per idle period
        if (!bus_idle)
        begin
            d.idle_cnt = '0;
        end
        else if (q.idle_cnt != udc_pkg::IDLE_CNT_W'(SUSPEND_CYCLES))
        begin
            d.idle_cnt = q.idle_cnt + 1'b1;
        end
        d.idle_prev = bus_idle;

        // Event sets, independent of the enables
        if (bus_idle && q.idle_cnt == udc_pkg::IDLE_CNT_W'(SUSPEND_CYCLES - 1))
        begin
            d.flags[udc_pkg::FL_SUSP] = 1'b1;
        end

        // Wake on the idle-to-active edge
        if (q.idle_prev && !bus_idle)
        begin
            d.flags[udc_pkg::FL_WAKE] = 1'b1;
        end

        if (resume_end_evt)
        begin
            d.flags[udc_pkg::FL_RESUME] = 1'b1;
        end

        if (bus_reset_end_evt)
        begin
            d.flags[udc_pkg::FL_RESET] = 1'b1;
        end

        if (remote_resume_sent_evt)
        begin
            d.flags[udc_pkg::FL_REMOTE] = 1'b1;
        end

        // Frame number is taken even from a corrupted SOF
        if (sof_evt)
        begin
            d.flags[udc_pkg::FL_SOF] = 1'b1;
            d.frame = sof_frame;
            d.fn_err = sof_crc_bad;
        end

        // Before enabling, only the default address zero is answered
        d.addr_hit = tok_valid && (q.addr_valid ? (tok_addr == q.dev_addr) : (tok_addr == 7'h00));
        d.irq = cpu_global_ie && |(q.flags & q.ien & udc_pkg::FLAG_MASK);

        // Address phase; read data sampled from the next state so a preceding write shows
        if (hsel && hready && htrans[1])
        begin
            d.dp_wr = hwrite;
            d.dp_off = haddr[7:0];
            d.rdata = hwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte(d, haddr[7:0])};
        end
        else
        begin
            d.dp_wr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.flags <= udc_pkg::RST_FLAGS;
            q.ien <= udc_pkg::RST_IEN;
            q.dev_addr <= udc_pkg::RST_ADDR[6:0];
            // Low so reset release is no wake edge
            q.idle_prev <= 1'b0;
            q.hready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs come straight from the state register; responses are always OKAY
    assign hrdata = q.rdata;
    assign hreadyout = q.hready;
    assign hresp = 1'b0;
    assign usb_irq_req = q.irq;
    assign addr_hit = q.addr_hit;

    // Endpoint controls to the USB side
    assign endpoint_hold_reset = q.ep_rst;
    assign endpoint_active = q.ep_act;
    assign stall_request = q.ep_stall;
    assign toggle_reset = q.ep_tgl;
    assign endpoint_transfer_kind = q.ep_kind;
    assign endpoint_direction = q.ep_dir_eff;

    // Checks
    property p_sof_flag;
        @(posedge hclk) disable iff (!hresetn)
        sof_evt |=> q.flags[udc_pkg::FL_SOF] && (q.frame == $past(sof_frame));
    endproperty
    a_sof_flag: assert property (p_sof_flag) else $error("SOF flag or frame not captured");

    property p_crc_err;
        @(posedge hclk) disable iff (!hresetn)
        (sof_evt && sof_crc_bad) |=> q.fn_err && q.flags[udc_pkg::FL_SOF];
    endproperty
    a_crc_err: assert property (p_crc_err) else $error("Bad SOF did not set both bits");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        (cpu_global_ie && |(q.flags & q.ien)) |=> usb_irq_req;
    endproperty
    a_irq: assert property (p_irq) else $error("Enabled flag gave no interrupt");

    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        (!cpu_global_ie || (q.flags & q.ien) == 8'h00) |=> !usb_irq_req;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without enabled flag");

    property p_flag_clear;
        @(posedge hclk) disable iff (!hresetn)
        (q.dp_wr && q.dp_off == udc_pkg::OFF_FLAGS && !hwdata[udc_pkg::FL_SOF] && !sof_evt)
            |=> !q.flags[udc_pkg::FL_SOF];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Zero write did not clear flag");

    property p_suspend;
        @(posedge hclk) disable iff (!hresetn)
        $rose(q.flags[udc_pkg::FL_SUSP]) |-> $past(bus_idle)
            && $past(q.idle_cnt) == udc_pkg::IDLE_CNT_W'(SUSPEND_CYCLES - 1);
    endproperty
    a_suspend: assert property (p_suspend) else $error("Suspend flag without idle bus");

    property p_addr;
        @(posedge hclk) disable iff (!hresetn)
        (tok_valid && tok_addr != 7'h00 && !q.addr_valid) |=> !addr_hit;
    endproperty
    a_addr: assert property (p_addr) else $error("Answered address before enable");

    property p_toggle;
        @(posedge hclk) disable iff (!hresetn)
        (toggle_reset != 5'h00) |-> $past(q.dp_wr && q.dp_off == udc_pkg::OFF_EP_CTL)
            && $past(hwdata[udc_pkg::EPC_TOGGLE]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("Toggle reset without write");

    property p_cancel;
        @(posedge hclk) disable iff (!hresetn)
        (q.dp_wr && q.dp_off == udc_pkg::OFF_EP_CTL && hwdata[udc_pkg::EPC_CANCEL])
            |=> (stall_request & ep_onehot($past(q.ep_sel))) == 5'h00;
    endproperty
    a_cancel: assert property (p_cancel) else $error("Stall cancel left stall pending");

    property p_ready;
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp;
    endproperty
    a_ready: assert property (p_ready) else $error("Slave stalled or erred");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        $fell(bus_idle) |=> q.flags[udc_pkg::FL_WAKE];
    endproperty
    a_wake: assert property (p_wake) else $error("Wake flag not set");

    property p_stall_hw;
        @(posedge hclk) disable iff (!hresetn)
        ((stall_sent_evt || setup_rcvd_evt) && !(q.dp_wr && q.dp_off == udc_pkg::OFF_EP_CTL))
            |=> (stall_request & ep_onehot($past(xfer_ep))) == 5'h00;
    endproperty
    a_stall_hw: assert property (p_stall_hw) else $error("Stall survived handshake");

    property p_ep_hold;
        @(posedge hclk) disable iff (!hresetn)
        (q.dp_wr && q.dp_off == udc_pkg::OFF_EP_RST)
            |=> endpoint_hold_reset == $past(hwdata[4:0]);
    endproperty
    a_ep_hold: assert property (p_ep_hold) else $error("Endpoint reset not applied");

    // Coverage of the main scenarios
    c_sof_bad: cover property (@(posedge hclk) disable iff (!hresetn) sof_evt && sof_crc_bad);

    c_suspend: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(q.flags[udc_pkg::FL_SUSP]));

    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(usb_irq_req));

    c_stall: cover property (@(posedge hclk) disable iff (!hresetn)
        $fell(stall_request[2]) && stall_sent_evt);
endmodule // udc_regs

/* File: test/testbench.sv */
// Self-checking bench for the device register block driven over AHB-Lite
`timescale 1ns/1ps
module testbench;
    localparam int SUSP = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic cpu_global_ie = 1'b0;
    logic hready_bus;
    logic [31:0] hrdata;
    logic hreadyout, hresp, usb_irq_req, addr_hit;
    logic resume_end_evt, bus_reset_end_evt, remote_resume_sent_evt, bus_idle, sof_evt;
    logic sof_crc_bad, tok_valid, stall_sent_evt, setup_rcvd_evt;
    logic [10:0] sof_frame;
    logic [6:0] tok_addr;
    logic [2:0] xfer_ep;
    logic [4:0] ep_hold, ep_act, ep_stall, ep_tgl, ep_dir;
    logic [9:0] ep_kind;
    logic [31:0] rd;
    logic [10:0] f;
    logic [1:0] k;
    logic d, bad;
    logic [7:0] tgl_cnt = 8'h00;
    int seed, error_cnt, n_compared, i;

    assign hready_bus = hreadyout;
    // Half period of 2.5 ns gives 200 MHz
    always #2.5 hclk = ~hclk;
    // Count toggle-reset pulses on endpoint 2
    always @(posedge hclk) if (ep_tgl[2] === 1'b1) tgl_cnt <= tgl_cnt + 8'h01;

    udc_host_model host (.hclk(hclk), .resume_end_evt(resume_end_evt),
        .bus_reset_end_evt(bus_reset_end_evt), .remote_resume_sent_evt(remote_resume_sent_evt),
        .bus_idle(bus_idle), .sof_evt(sof_evt), .sof_crc_bad(sof_crc_bad),
        .sof_frame(sof_frame), .tok_valid(tok_valid), .tok_addr(tok_addr),
        .stall_sent_evt(stall_sent_evt), .setup_rcvd_evt(setup_rcvd_evt), .xfer_ep(xfer_ep));
    udc_regs #(.SUSPEND_CYCLES(SUSP)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready_bus),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .resume_end_evt(resume_end_evt), .bus_reset_end_evt(bus_reset_end_evt),
        .remote_resume_sent_evt(remote_resume_sent_evt), .bus_idle(bus_idle),
        .sof_evt(sof_evt), .sof_crc_bad(sof_crc_bad), .sof_frame(sof_frame),
        .tok_valid(tok_valid), .tok_addr(tok_addr), .stall_sent_evt(stall_sent_evt),
        .setup_rcvd_evt(setup_rcvd_evt), .xfer_ep(xfer_ep), .cpu_global_ie(cpu_global_ie),
        .usb_irq_req(usb_irq_req), .addr_hit(addr_hit), .endpoint_hold_reset(ep_hold),
        .endpoint_active(ep_act), .stall_request(ep_stall), .toggle_reset(ep_tgl),
        .endpoint_transfer_kind(ep_kind), .endpoint_direction(ep_dir));

    // Single comparison point; every check is counted
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One AHB single transfer; waits on hready in both phases, outputs settled on return
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready_bus !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready_bus !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, $random(seed));
        chk(name, rd, exp);
    endtask
    // Flag position for event kinds 0 to 2 of the model, the SOF flag for any other
    function automatic int bit_of(input int kind);
        case (kind)
            0: return udc_pkg::FL_RESUME;
            1: return udc_pkg::FL_RESET;
            2: return udc_pkg::FL_REMOTE;
            default: return udc_pkg::FL_SOF;
        endcase
    endfunction
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog far past the expected run
    initial
    begin
        #50000;
        error_cnt++;
        finish_test;
    end

    initial
    begin
        seed = 35337;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // Everything reads zero after reset, unmapped place too
        for (i = 0; i < 11; i++) rdc("reset_val", 8'(4 * i), 32'h0000_0000);
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0001);
        chk("ep0_active", 32'(ep_act), 32'h0000_0001);
        $display("test reset done");
        // Each event sets its flag with enables off; ones keep it, zero clears it
        for (i = 0; i < 4; i++)
        begin
            if (i == 3) host.sof(11'h155, 1'b0);
            else host.pulse(i, 3'h0);
            if (i == 1) bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0001);
            rdc("flag_set", udc_pkg::OFF_FLAGS, 32'(1) << bit_of(i));
            bus(1'b1, udc_pkg::OFF_FLAGS, 32'h0000_00FF);
            rdc("flag_keep", udc_pkg::OFF_FLAGS, 32'(1) << bit_of(i));
            bus(1'b1, udc_pkg::OFF_FLAGS, ~(32'(1) << bit_of(i)));
            rdc("flag_clr", udc_pkg::OFF_FLAGS, 32'h0000_0000);
        end
        $display("test flags done");
        // Request needs flag, enable and global enable together
        bus(1'b1, udc_pkg::OFF_IEN, 32'h0000_00FF);
        rdc("ien_rb", udc_pkg::OFF_IEN, 32'(udc_pkg::FLAG_MASK));
        host.sof(11'h2AA, 1'b0);
        repeat (3) @(posedge hclk);
        chk("irq_no_gie", 32'(usb_irq_req), 32'h0000_0000);
        cpu_global_ie <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("irq_on", 32'(usb_irq_req), 32'h0000_0001);
        bus(1'b1, udc_pkg::OFF_IEN, 32'h0000_0000);
        repeat (2) @(posedge hclk);
        chk("irq_no_ien", 32'(usb_irq_req), 32'h0000_0000);
        bus(1'b1, udc_pkg::OFF_FLAGS, 32'h0000_0000);
        $display("test irq done");
        // Random frames, good and corrupted
        repeat (6)
        begin
            f = 11'($random(seed));
            bad = 1'($random(seed));
            host.sof(f, bad);
            rdc("frame_counter_value_hi", udc_pkg::OFF_FRAME_COUNTER_VALUE_HI, {29'h0000_0000, f[10:8]});
            rdc("frame_counter_value_lo", udc_pkg::OFF_FRAME_COUNTER_VALUE_LO, {24'h00_0000, f[7:0]});
            rdc("fn_err", udc_pkg::OFF_FN_ERR, 32'(bad) << udc_pkg::FN_CRC_BIT);
            rdc("sof_flag", udc_pkg::OFF_FLAGS, 32'(1) << udc_pkg::FL_SOF);
            bus(1'b1, udc_pkg::OFF_FLAGS, 32'h0000_0000);
        end
        $display("test frame done");
        // Suspend only after the full idle span, wake on activity
        host.idle(1'b1);
        repeat (SUSP / 2) @(posedge hclk);
        rdc("susp_early", udc_pkg::OFF_FLAGS, 32'h0000_0000);
        repeat (SUSP) @(posedge hclk);
        rdc("susp", udc_pkg::OFF_FLAGS, 32'(1) << udc_pkg::FL_SUSP);
        host.idle(1'b0);
        repeat (2) @(posedge hclk);
        rdc("wake", udc_pkg::OFF_FLAGS, 32'h0000_0011);
        bus(1'b1, udc_pkg::OFF_FLAGS, 32'h0000_0000);
        $display("test suspend done");
        // Address answered only once enabled
        host.token(7'h2A);
        #1;
        chk("hit_off", 32'(addr_hit), 32'h0000_0000);
        bus(1'b1, udc_pkg::OFF_ADDR, 32'h0000_00AA);
        rdc("addr_rb", udc_pkg::OFF_ADDR, 32'h0000_00AA);
        host.token(7'h2A);
        #1;
        chk("hit_on", 32'(addr_hit), 32'h0000_0001);
        $display("test address done");
        // Per-endpoint type, direction and enable through the select field
        for (i = 0; i < 5; i++)
        begin
            k = 2'($random(seed));
            d = 1'($random(seed));
            bus(1'b1, udc_pkg::OFF_EP_SEL, 32'hFFFF_FFF8 | 32'(i));
            rdc("sel_rb", udc_pkg::OFF_EP_SEL, 32'(i));
            bus(1'b1, udc_pkg::OFF_EP_CFG, {24'hFFFF_FF, k, 5'h1F, d});
            bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0001);
            rdc("cfg_rb", udc_pkg::OFF_EP_CFG, {24'h00_0000, k, 5'h00, d});
            chk("kind", 32'(ep_kind[2 * i +: 2]), 32'(k));
            chk("dir", 32'(ep_dir[i]), 32'((k != 2'b00) & d));
            chk("act", 32'(ep_act[i]), 32'h0000_0001);
        end
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0000);
        chk("deact", 32'(ep_act), 32'h0000_000F);
        bus(1'b1, udc_pkg::OFF_EP_SEL, 32'h0000_0005);
        rdc("sel_none", udc_pkg::OFF_EP_CTL, 32'h0000_0000);
        f = 11'($random(seed));
        bus(1'b1, udc_pkg::OFF_EP_RST, {21'h00_0000, f});
        chk("ep_hold", 32'(ep_hold), 32'(f[4:0]));
        rdc("rst_rb", udc_pkg::OFF_EP_RST, 32'(f[4:0]));
        bus(1'b1, udc_pkg::OFF_EP_RST, 32'h0000_0000);
        chk("ep_free", 32'(ep_hold), 32'h0000_0000);
        $display("test endpoint done");
        // Stall set, cleared by hardware, cancelled; toggle reset pulses once
        bus(1'b1, udc_pkg::OFF_EP_SEL, 32'h0000_0002);
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0021);
        chk("stall_set", 32'(ep_stall), 32'h0000_0004);
        host.pulse(4, 3'h2);
        #1;
        chk("stall_sent", 32'(ep_stall), 32'h0000_0000);
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0021);
        host.pulse(5, 3'h2);
        #1;
        chk("stall_setup", 32'(ep_stall), 32'h0000_0000);
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0021);
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0011);
        chk("stall_cancel", 32'(ep_stall), 32'h0000_0000);
        rdc("cancel_rb", udc_pkg::OFF_EP_CTL, 32'h0000_0001);
        bus(1'b1, udc_pkg::OFF_EP_CTL, 32'h0000_0009);
        repeat (2) @(posedge hclk);
        chk("tgl_pulse", 32'(tgl_cnt), 32'h0000_0001);
        rdc("tgl_rb", udc_pkg::OFF_EP_CTL, 32'h0000_0001);
        $display("test stall done");
        finish_test;
    end
endmodule // testbench

/* File: test/udc_host_model.sv */
// USB-side event source standing in for host traffic seen by the register block
`timescale 1ns/1ps
module udc_host_model (
    input wire logic hclk,
    output logic resume_end_evt,
    output logic bus_reset_end_evt,
    output logic remote_resume_sent_evt,
    output logic bus_idle,
    output logic sof_evt,
    output logic sof_crc_bad,
    output logic [10:0] sof_frame,
    output logic tok_valid,
    output logic [6:0] tok_addr,
    output logic stall_sent_evt,
    output logic setup_rcvd_evt,
    output logic [2:0] xfer_ep
);
    // Lines start active so no suspend count runs before the bench asks for it
    initial
    begin
        {resume_end_evt, bus_reset_end_evt, remote_resume_sent_evt} = 3'h0;
        {sof_evt, tok_valid, stall_sent_evt, setup_rcvd_evt} = 4'h0;
        bus_idle = 1'b0;
        sof_crc_bad = 1'b0;
        sof_frame = 11'h000;
        tok_addr = 7'h00;
        xfer_ep = 3'h0;
    end
    // One-cycle pulse: 0 resume end, 1 bus reset end, 2 remote resume, 4 stall sent, 5 setup
    task automatic pulse(input int kind, input logic [2:0] ep);
        @(posedge hclk);
        xfer_ep <= ep;
        case (kind)
            0: resume_end_evt <= 1'b1;
            1: bus_reset_end_evt <= 1'b1;
            2: remote_resume_sent_evt <= 1'b1;
            4: stall_sent_evt <= 1'b1;
            default: setup_rcvd_evt <= 1'b1;
        endcase
        @(posedge hclk);
        {resume_end_evt, bus_reset_end_evt, remote_resume_sent_evt} <= 3'h0;
        {stall_sent_evt, setup_rcvd_evt} <= 2'h0;
        xfer_ep <= ~ep;
    endtask
    // Frame packet; qualifiers are scrambled afterwards so stale values are never trusted
    task automatic sof(input logic [10:0] f, input logic bad);
        @(posedge hclk);
        sof_evt <= 1'b1;
        sof_frame <= f;
        sof_crc_bad <= bad;
        @(posedge hclk);
        sof_evt <= 1'b0;
        sof_frame <= ~f;
        sof_crc_bad <= ~bad;
    endtask
    // Token address seen on the bus
    task automatic token(input logic [6:0] a);
        @(posedge hclk);
        tok_valid <= 1'b1;
        tok_addr <= a;
        @(posedge hclk);
        tok_valid <= 1'b0;
        tok_addr <= ~a;
    endtask
    // Line state: high while the bus is idle
    task automatic idle(input logic v);
        @(posedge hclk);
        bus_idle <= v;
    endtask
endmodule // udc_host_model
